// ### kmc_mode_ctrl.v
// Contract
// RULE1 - Power-up lights all segments, held longer while confirm held, then monitors
// RULE2 - Decimal point blinks while monitoring
// RULE3 - Test and programming are entered only from monitoring
// RULE4 - Confirm plus up or down held enters test mode
// RULE5 - Test mode evaluates relays at set values shifted 15% up and down
// RULE6 - Releasing test keys returns to monitoring
// RULE7 - Test entry drives relays from live measurement
// RULE8 - Program key in monitoring starts programming at the code step
// RULE9 - Stages: code 1-5, standard 1-3,6-16, special 17-22 via left+right
// RULE10 - Cursor blinks on the entry being edited
// RULE11 - Five idle minutes abort programming and restore settings
// RULE12 - Entries take effect only when confirmed; whole sequence must complete
// RULE13 - Program key during programming aborts and restores settings
// RULE14 - Standard unit code is zero; code steps may be skipped
// RULE15 - After a new code the display shows dashes only
// RULE16 - Factory unit holds code ones, shown as dashes
// RULE17 - Existing code must match before a replacement is accepted
// RULE18 - Unit step cycles through fifteen units
// RULE19 - Signal defaults: rpm, 60 pulses, pnp, 15 periods, 6,0 V
// RULE20 - Relay defaults 1000,0/850,0 and 3,0/1,0, over-speed, nc
// RULE21 - Switch-back delay and bridge time default zero, relay one only
// RULE22 - Over-speed alarm when speed exceeds upper limit
// RULE23 - Reset restarts at lamp test with defaults or stored parameters
`timescale 1ns/1ps
`include "kmc_defines.vh"
module kmc_mode_ctrl #(
    parameter FACTORY = 0,
    parameter [33:0] LAMP_CYC = `KMC_LAMP_MS * (`KMC_CLK_HZ / 34'h3E8),
    parameter [33:0] BLINK_CYC = `KMC_BLINK_MS * (`KMC_CLK_HZ / 34'h3E8),
    parameter [33:0] IDLE_CYC = `KMC_IDLE_S * `KMC_CLK_HZ
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire key_ok,
    input wire key_up,
    input wire key_down,
    input wire key_left,
    input wire key_right,
    input wire program_key,
    input wire [19:0] speed,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg seg_all_on,
    output reg dp_on,
    output reg cursor_on,
    output reg code_dashes,
    output reg relay1_coil,
    output reg relay2_coil,
    output reg [1:0] mode_out,
    output reg [4:0] step_out
);

// ----------------------------------------
// Factory default per slot
// ----------------------------------------
function [19:0] dflt;
    input [4:0] i;
    begin
        case (i)
            `KMC_P_CODE: dflt = (FACTORY != 0) ? `KMC_D_CODE_FAC : `KMC_D_CODE_STD; // [RULE14] [RULE16]
            5'h07: dflt = `KMC_D_PULSES; // [RULE19]
            `KMC_P_LIM1: dflt = `KMC_D_LIM1; // [RULE20]
            `KMC_P_NC1: dflt = `KMC_D_NC;
            `KMC_P_BACK1: dflt = `KMC_D_BACK1;
            5'h0E: dflt = `KMC_D_OFFS;
            5'h0F: dflt = `KMC_D_SCALE;
            5'h14: dflt = `KMC_D_PERIODS; // [RULE19]
            5'h15: dflt = `KMC_D_TRIG;
            `KMC_P_LIM2: dflt = `KMC_D_LIM2; // [RULE20]
            5'h1A: dflt = `KMC_D_NC;
            `KMC_P_BACK2: dflt = `KMC_D_BACK2;
            default: dflt = 20'h00000; // Unit rpm, pnp, over, delays zero [RULE19] [RULE21]
        endcase
    end
endfunction

// ----------------------------------------
// Step order, relay two slots after 13
// ----------------------------------------
function [4:0] nxt;
    input [4:0] s;
    begin
        case (s)
            5'h0D: nxt = 5'h18;
            5'h1B: nxt = 5'h0E;
            default: nxt = s + 5'h01;
        endcase
    end
endfunction

// ----------------------------------------
// Key synchronisers
// ----------------------------------------
wire [5:0] key_pin = {program_key, key_right, key_left, key_down, key_up, key_ok};
reg [5:0] s1_reg;
reg [5:0] s2_reg;
reg [5:0] s3_reg;
reg [5:0] key_reg;
reg [5:0] key_old_reg;

// Level changes once stages two and three agree
always @(posedge clk) begin
    if (srst) begin
        s1_reg <= 6'h00;
        s2_reg <= 6'h00;
        s3_reg <= 6'h00;
        key_reg <= 6'h00;
        key_old_reg <= 6'h00;
    end else if (ce) begin
        s1_reg <= key_pin;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        key_reg <= (s2_reg & s3_reg) | (key_reg & (s2_reg | s3_reg));
        key_old_reg <= key_reg;
    end
end

wire [5:0] press = key_reg & ~key_old_reg;
wire any_press = |press;
wire k_ok = press[0];
wire test_up = key_reg[0] & key_reg[1];
wire test_dn = key_reg[0] & key_reg[2];
wire both_lr = key_reg[3] & key_reg[4] & (press[3] | press[4]);

// ----------------------------------------
// State
// ----------------------------------------
reg [19:0] live_mem [0:31];
reg [19:0] shad_mem [0:31];
reg [1:0] mode_reg;
reg [4:0] step_reg;
reg [19:0] edit_reg;
reg [33:0] tmr_reg;
reg [33:0] blink_cnt_reg;
reg blink_reg;
reg freeze_reg;
reg al1_reg;
reg al2_reg;
reg commit_std;
reg commit_all;
reg abort_p;

wire [19:0] code_live = live_mem[`KMC_P_CODE];

// Blink base for decimal point and cursor
always @(posedge clk) begin
    if (srst) begin
        blink_cnt_reg <= 34'h0;
        blink_reg <= 1'b0;
    end else if (ce) begin
        if (blink_cnt_reg >= BLINK_CYC - 34'h1) begin
            blink_cnt_reg <= 34'h0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 34'h1;
        end
    end
end

// ----------------------------------------
// Mode sequencer
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        commit_std <= 1'b0;
        commit_all <= 1'b0;
        abort_p <= 1'b0;
        mode_reg <= `KMC_M_LAMP; // [RULE23]
        step_reg <= 5'h00;
        edit_reg <= 20'h00000;
        tmr_reg <= 34'h0;
    end else if (ce) begin
        commit_std <= 1'b0;
        commit_all <= 1'b0;
        abort_p <= 1'b0;
        case (mode_reg)
            `KMC_M_LAMP: begin
                if (key_reg[0]) begin
                    tmr_reg <= 34'h0; // Held confirm extends test [RULE1]
                end else if (tmr_reg >= LAMP_CYC - 34'h1) begin
                    mode_reg <= `KMC_M_MON; // [RULE1]
                end else begin
                    tmr_reg <= tmr_reg + 34'h1;
                end
            end
            `KMC_M_MON: begin
                if (freeze_reg) begin
                    mode_reg <= `KMC_M_MON;
                end else if (test_up | test_dn) begin
                    mode_reg <= `KMC_M_TEST; // [RULE3] [RULE4]
                end else if (press[5]) begin
                    mode_reg <= `KMC_M_PROGRAM_KEY; // [RULE3] [RULE8]
                    step_reg <= `KMC_S_FIRST;
                    tmr_reg <= 34'h0;
                end
            end
            `KMC_M_TEST: begin
                if (!(test_up | test_dn)) begin
                    mode_reg <= `KMC_M_MON; // [RULE6]
                end
            end
            default: begin
                tmr_reg <= any_press ? 34'h0 : tmr_reg + 34'h1;
                if (press[5] || tmr_reg >= IDLE_CYC - 34'h1) begin
                    mode_reg <= `KMC_M_MON; // [RULE11] [RULE13]
                    abort_p <= 1'b1;
                    step_reg <= 5'h00;
                end else if (step_reg == `KMC_S_STORE && both_lr) begin
                    step_reg <= `KMC_S_SPEC; // [RULE9]
                    edit_reg <= shad_mem[`KMC_S_SPEC];
                end else if (press[1] && step_reg != `KMC_S_FIRST) begin
                    if (step_reg == `KMC_S_UNIT && edit_reg >= `KMC_UNITS) begin
                        edit_reg <= 20'h00000; // [RULE18]
                    end else begin
                        edit_reg <= edit_reg + 20'h00001;
                    end
                end else if (press[2] && step_reg != `KMC_S_FIRST) begin
                    if (step_reg == `KMC_S_UNIT && edit_reg == 20'h00000) begin
                        edit_reg <= `KMC_UNITS; // [RULE18]
                    end else begin
                        edit_reg <= edit_reg - 20'h00001;
                    end
                end else if (press[4] && step_reg == `KMC_S_CODE_IN && code_live == 20'h00000) begin
                    step_reg <= `KMC_S_CODE_END; // Open code, skip change steps [RULE14]
                end else if (k_ok) begin
                    if (step_reg == `KMC_S_FIRST) begin
                        step_reg <= `KMC_S_CODE_IN;
                        edit_reg <= 20'h00000;
                    end else if (step_reg == `KMC_S_CODE_IN) begin
                        if (code_live == 20'h00000 || edit_reg == code_live) begin
                            step_reg <= `KMC_S_CODE_NEW; // [RULE17]
                            edit_reg <= shad_mem[`KMC_S_CODE_NEW];
                        end else begin
                            edit_reg <= 20'h00000; // Wrong code, try again [RULE17]
                        end
                    end else if (step_reg == `KMC_S_STORE) begin
                        mode_reg <= `KMC_M_MON;
                        commit_std <= 1'b1; // [RULE12]
                        step_reg <= 5'h00;
                    end else if (step_reg == `KMC_S_LAST) begin
                        mode_reg <= `KMC_M_MON;
                        commit_all <= 1'b1; // [RULE12]
                        step_reg <= 5'h00;
                    end else if (step_reg == 5'h0F) begin
                        step_reg <= `KMC_S_STORE;
                    end else begin
                        step_reg <= nxt(step_reg); // [RULE9] [RULE12]
                        edit_reg <= shad_mem[nxt(step_reg)];
                    end
                end
            end
        endcase
    end
end

// ----------------------------------------
// Parameter store: live copy and edit copy
// ----------------------------------------
wire bus_wr = avs_write & ~avs_waitrequest;
wire [4:0] bus_idx = avs_address[6:2];
wire bus_prm = avs_address[7];
wire conf = ce & (mode_reg == `KMC_M_PROGRAM_KEY) & k_ok & ~press[5];
wire prm_step = (step_reg >= `KMC_S_CODE_NEW && step_reg != `KMC_S_STORE) && !(step_reg == 5'h04);

genvar gi;
generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_prm
        localparam [4:0] IDX = gi;
        // Live set changes only on a completed sequence or bus load
        always @(posedge clk) begin
            if (srst) begin
                live_mem[gi] <= dflt(IDX); // [RULE23]
            end else if (ce) begin
                if (commit_all || (commit_std && !(gi > 16 && gi < 22))) begin
                    live_mem[gi] <= shad_mem[gi]; // [RULE12]
                end else if (bus_wr && bus_prm && bus_idx == IDX && mode_reg != `KMC_M_PROGRAM_KEY) begin
                    live_mem[gi] <= avs_writedata[19:0]; // [RULE23]
                end
            end
        end
        // Edit copy is reloaded from live on entry and on abort
        always @(posedge clk) begin
            if (srst) begin
                shad_mem[gi] <= dflt(IDX);
            end else if (ce) begin
                if (mode_reg != `KMC_M_PROGRAM_KEY || abort_p) begin
                    shad_mem[gi] <= live_mem[gi]; // [RULE11] [RULE13]
                end else if (conf && prm_step && step_reg == IDX) begin
                    shad_mem[gi] <= edit_reg; // [RULE12] [RULE17]
                end
            end
        end
    end
endgenerate

// ----------------------------------------
// Relay decision
// ----------------------------------------
wire [19:0] lim1 = live_mem[`KMC_P_LIM1];
wire [19:0] lim2 = live_mem[`KMC_P_LIM2];
wire [27:0] l1_lo = (lim1 * 8'h55) / 8'h64;
wire [27:0] l1_hi = (lim1 * 8'h73) / 8'h64;
wire [27:0] l2_lo = (lim2 * 8'h55) / 8'h64;
wire [27:0] l2_hi = (lim2 * 8'h73) / 8'h64;
wire in_test = mode_reg == `KMC_M_TEST;
wire [19:0] t1 = !in_test ? lim1 : test_up ? l1_lo[19:0] : l1_hi[19:0]; // [RULE5]
wire [19:0] t2 = !in_test ? lim2 : test_up ? l2_lo[19:0] : l2_hi[19:0]; // [RULE5]
wire over1 = ~live_mem[`KMC_P_DIR1][0];
wire over2 = ~live_mem[5'h19][0];
wire trip1 = over1 ? (speed > t1) : (speed < t1); // [RULE22]
wire trip2 = over2 ? (speed > t2) : (speed < t2);
wire clr1 = over1 ? (speed < live_mem[`KMC_P_BACK1]) : (speed > live_mem[`KMC_P_BACK1]);
wire clr2 = over2 ? (speed < live_mem[`KMC_P_BACK2]) : (speed > live_mem[`KMC_P_BACK2]);
wire run = (mode_reg == `KMC_M_MON) | in_test;

// Alarm with hysteresis; test uses live speed at once
always @(posedge clk) begin
    if (srst) begin
        al1_reg <= 1'b0;
        al2_reg <= 1'b0;
    end else if (ce && run) begin
        if (trip1) begin
            al1_reg <= 1'b1; // [RULE7] [RULE22]
        end else if (clr1 || in_test) begin
            al1_reg <= 1'b0;
        end
        if (trip2) begin
            al2_reg <= 1'b1; // [RULE7]
        end else if (clr2 || in_test) begin
            al2_reg <= 1'b0;
        end
    end
end

// ----------------------------------------
// Bus slave, one wait cycle per access
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
        freeze_reg <= 1'b0;
    end else if (ce) begin
        avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        if (bus_wr && avs_address == `KMC_A_CTRL) begin
            freeze_reg <= avs_writedata[0];
        end
        if (avs_read && avs_waitrequest) begin
            if (bus_prm) begin
                avs_readdata <= {12'h000, live_mem[bus_idx]};
            end else if (avs_address == `KMC_A_STAT) begin
                avs_readdata <= {23'h000000, al2_reg, al1_reg, step_reg, mode_reg};
            end else if (avs_address == `KMC_A_CTRL) begin
                avs_readdata <= {31'h00000000, freeze_reg};
            end else if (avs_address == `KMC_A_SPEED) begin
                avs_readdata <= {12'h000, speed};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end
end

// ----------------------------------------
// Panel outputs
// ----------------------------------------
always @(posedge clk) begin
    if (srst) begin
        seg_all_on <= 1'b1;
        dp_on <= 1'b0;
        cursor_on <= 1'b0;
        code_dashes <= 1'b0;
        relay1_coil <= 1'b0;
        relay2_coil <= 1'b0;
        mode_out <= `KMC_M_LAMP;
        step_out <= 5'h00;
    end else if (ce) begin
        seg_all_on <= mode_reg == `KMC_M_LAMP; // [RULE1]
        dp_on <= (mode_reg == `KMC_M_MON) & blink_reg; // [RULE2]
        cursor_on <= (mode_reg == `KMC_M_PROGRAM_KEY) & blink_reg; // [RULE10]
        code_dashes <= code_live != 20'h00000; // [RULE15] [RULE16]
        relay1_coil <= al1_reg ^ live_mem[`KMC_P_NC1][0];
        relay2_coil <= al2_reg ^ live_mem[5'h1A][0];
        mode_out <= mode_reg;
        step_out <= step_reg;
    end
end

endmodule // kmc_mode_ctrl

// ### kmc_defines.vh
`ifndef KMC_DEFINES_VH
`define KMC_DEFINES_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define KMC_CLK_HZ 34'h1312D00
`define KMC_LAMP_MS 34'h3E8
`define KMC_BLINK_MS 34'h1F4
`define KMC_IDLE_S 34'h12C
// ----------------------------------------
// Modes and steps
// ----------------------------------------
`define KMC_M_LAMP 2'h0
`define KMC_M_MON 2'h1
`define KMC_M_TEST 2'h2
`define KMC_M_PROGRAM_KEY 2'h3
`define KMC_S_FIRST 5'h01
`define KMC_S_CODE_IN 5'h02
`define KMC_S_CODE_NEW 5'h03
`define KMC_S_CODE_END 5'h05
`define KMC_S_UNIT 5'h06
`define KMC_S_STORE 5'h10
`define KMC_S_SPEC 5'h11
`define KMC_S_LAST 5'h16
`define KMC_UNITS 20'h0000E
// ----------------------------------------
// Parameter slots and defaults
// ----------------------------------------
`define KMC_P_CODE 5'h03
`define KMC_P_LIM1 5'h0A
`define KMC_P_DIR1 5'h0B
`define KMC_P_NC1 5'h0C
`define KMC_P_BACK1 5'h0D
`define KMC_P_LIM2 5'h18
`define KMC_P_BACK2 5'h1B
`define KMC_D_CODE_STD 20'h00000
`define KMC_D_CODE_FAC 20'h11111
`define KMC_D_PULSES 20'h0003C
`define KMC_D_LIM1 20'h02710
`define KMC_D_BACK1 20'h02134
`define KMC_D_OFFS 20'h00004
`define KMC_D_SCALE 20'h003E8
`define KMC_D_PERIODS 20'h0000F
`define KMC_D_TRIG 20'h0003C
`define KMC_D_LIM2 20'h0001E
`define KMC_D_BACK2 20'h0000A
`define KMC_D_NC 20'h00001
// ----------------------------------------
// Bus map
// ----------------------------------------
`define KMC_A_STAT 8'h00
`define KMC_A_CTRL 8'h04
`define KMC_A_SPEED 8'h08
`define KMC_A_PARAM 8'h80
`endif

// ### kmc_mode_ctrl_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Checker on the mode controller ports
// ----------------------------------------
module kmc_mode_ctrl_monitor #(
    parameter [33:0] IDLE_CYC = 34'h0C8
) (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire key_ok,
    input wire key_up,
    input wire key_down,
    input wire key_left,
    input wire key_right,
    input wire program_key,
    input wire seg_all_on,
    input wire dp_on,
    input wire cursor_on,
    input wire [1:0] mode_out,
    input wire [4:0] step_out
);
    reg [33:0] idle_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !ce);
    // Cycles spent programming with every key up
    always @(posedge clk) begin
        if (srst || mode_out != 2'h3 || key_ok || key_up || key_down || key_left || key_right || program_key) begin
            idle_reg <= 34'h0;
        end else begin
            idle_reg <= idle_reg + 34'h1;
        end
    end
    AST_LAMP_SEG: assert property (mode_out == 2'h0 |-> seg_all_on)
        else $error("segments dark in lamp test");
    AST_DP_QUIET: assert property (mode_out != 2'h1 && $past(mode_out) != 2'h1 |-> !dp_on)
        else $error("point lit outside monitoring");
    AST_DP_BLINK: assert property ($rose(dp_on) |-> ##[3:5] !dp_on)
        else $error("point does not blink");
    AST_ENTRY_MON: assert property ($changed(mode_out) && mode_out[1] |-> $past(mode_out) == 2'h1)
        else $error("test or program entered from wrong mode");
    AST_TEST_END: assert property (mode_out == 2'h2 && !key_ok |-> ##[1:8] mode_out != 2'h2)
        else $error("test mode outlives key release");
    AST_PROGRAM_KEY_FIRST: assert property ($changed(mode_out) && mode_out == 2'h3 |-> ##[0:1] step_out == 5'h01)
        else $error("programming not at first step");
    AST_STEP_IDLE: assert property (mode_out != 2'h3 && $past(mode_out) != 2'h3 |-> step_out == 5'h00)
        else $error("step shown outside programming");
    AST_CURSOR_OFF: assert property (mode_out != 2'h3 && $past(mode_out) != 2'h3 |-> !cursor_on)
        else $error("cursor outside programming");
    AST_IDLE_EXIT: assert property (idle_reg < IDLE_CYC + 34'h10)
        else $error("idle programming not left");
    AST_PROGRAM_KEY_ABORT: assert property (mode_out == 2'h3 && $rose(program_key) |-> ##[1:8] mode_out == 2'h1)
        else $error("program key does not abort");
    COV_TEST: cover property (mode_out == 2'h2);
    COV_PROGRAM_KEY: cover property (mode_out == 2'h3);
    COV_SPECIAL: cover property (step_out == 5'h11);
endmodule // kmc_mode_ctrl_monitor

bind kmc_mode_ctrl kmc_mode_ctrl_monitor #(.IDLE_CYC(IDLE_CYC)) u_mon (.clk(clk), .srst(srst), .ce(ce),
    .key_ok(key_ok), .key_up(key_up), .key_down(key_down), .key_left(key_left), .key_right(key_right),
    .program_key(program_key), .seg_all_on(seg_all_on), .dp_on(dp_on), .cursor_on(cursor_on),
    .mode_out(mode_out), .step_out(step_out));

// ### kmc_panel.sv
`timescale 1ns/1ps
// ----------------------------------------
// Operator keypad model
// ----------------------------------------
module kmc_panel (
    input wire clk,
    output wire key_ok,
    output wire key_up,
    output wire key_down,
    output wire key_left,
    output wire key_right,
    output wire program_key
);
    reg [5:0] keys_reg = 6'h00;
    // Keys are plain levels, one bit each
    assign {program_key, key_right, key_left, key_down, key_up, key_ok} = keys_reg;
    // Hold a key pattern until told otherwise
    task hold(input [5:0] m);
        @(posedge clk);
        keys_reg <= m;
    endtask
    // One press then a quiet gap, so every entry is its own action
    task press(input [5:0] m);
        hold(m);
        repeat (8) @(posedge clk);
        keys_reg <= 6'h00;
        repeat (8) @(posedge clk);
    endtask
endmodule // kmc_panel

// ### kmc_mode_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module kmc_mode_ctrl_bench;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg ce = 1'b1;
    reg [19:0] speed = 20'h0;
    reg [7:0] avs_address = 8'h00;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [31:0] rd;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, seg_all_on, dp_on, cursor_on, code_dashes, relay1_coil, relay2_coil;
    wire key_ok, key_up, key_down, key_left, key_right, program_key;
    wire [1:0] mode_out;
    wire [4:0] step_out;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    localparam logic [4:0] SL [13] = '{5'h03, 5'h06, 5'h07, 5'h0A, 5'h0C, 5'h0D, 5'h12, 5'h13, 5'h14, 5'h15,
        5'h18, 5'h1A, 5'h1B};
    localparam logic [19:0] DV [13] = '{20'h0, 20'h0, 20'h3C, 20'h2710, 20'h1, 20'h2134, 20'h0, 20'h0, 20'hF,
        20'h3C, 20'h1E, 20'h1, 20'hA};
    kmc_panel panel (.clk(clk), .key_ok(key_ok), .key_up(key_up), .key_down(key_down), .key_left(key_left),
        .key_right(key_right), .program_key(program_key));
    kmc_mode_ctrl #(.LAMP_CYC(34'h14), .BLINK_CYC(34'h4), .IDLE_CYC(34'hC8)) DUT (.clk(clk), .srst(srst),
        .ce(ce), .key_ok(key_ok), .key_up(key_up), .key_down(key_down), .key_left(key_left),
        .key_right(key_right), .program_key(program_key), .speed(speed), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .seg_all_on(seg_all_on), .dp_on(dp_on), .cursor_on(cursor_on),
        .code_dashes(code_dashes), .relay1_coil(relay1_coil), .relay2_coil(relay2_coil), .mode_out(mode_out),
        .step_out(step_out));
    // ----------------------------------------
    // Clock, watchdog and verdict
    // ----------------------------------------
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    // One Avalon access, held until waitrequest is seen low
    task bus(input w, input [7:0] a, input [31:0] wd);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= wd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wait_mode(input [1:0] m);
        int n;
        n = 0;
        while (mode_out !== m && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK(mode_out, m)
    endtask
    task spd(input [19:0] v);
        speed <= v;
        repeat (10) @(posedge clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_lamp;
        int n;
        logic dp_prev;
        n = 0;
        @(posedge clk);
        `CHK(mode_out, 2'h0)
        repeat (30) @(posedge clk);
        `CHK(seg_all_on, 1'b1)
        panel.hold(6'h00);
        wait_mode(2'h1);
        `CHK(seg_all_on, 1'b0)
        dp_prev = dp_on;
        repeat (20) begin
            @(posedge clk);
            if (dp_on !== dp_prev) n++;
            dp_prev = dp_on;
        end
        `CHK(n > 3 && n < 6, 1'b1)
    endtask
    task t_defaults;
        `CHK(relay2_coil, 1'b1)
        bus(1'b1, 8'h40, 32'hFFFFF);
        bus(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 13; i++) begin
            bus(1'b0, 8'h80 + {SL[i], 2'b00}, 32'h0);
            `CHK(rd, {12'h000, DV[i]})
        end
    endtask
    task t_relay;
        spd(20'h01F40);
        `CHK(relay1_coil, 1'b1)
        spd(20'h02711);
        `CHK(relay1_coil, 1'b0)
        spd(20'h02328);
        `CHK(relay1_coil, 1'b0)
        spd(20'h01F40);
        `CHK(relay1_coil, 1'b1)
        speed <= 20'h02328;
        panel.hold(6'h03);
        wait_mode(2'h2);
        repeat (10) @(posedge clk);
        `CHK(relay1_coil, 1'b0)
        panel.hold(6'h23);
        repeat (12) @(posedge clk);
        `CHK(mode_out, 2'h2)
        speed <= 20'h01F40;
        panel.hold(6'h00);
        wait_mode(2'h1);
        panel.hold(6'h05);
        wait_mode(2'h2);
        spd(20'h02AF8);
        `CHK(relay1_coil, 1'b1)
        speed <= 20'h01F40;
        panel.hold(6'h00);
        wait_mode(2'h1);
    endtask
    task t_bus;
        `CHK(relay2_coil, 1'b0)
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h101)
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h01F40)
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h1)
        panel.press(6'h20);
        `CHK(mode_out, 2'h1)
        bus(1'b1, 8'h04, 32'h0);
        ce <= 1'b0;
        panel.press(6'h20);
        ce <= 1'b1;
        `CHK(mode_out, 2'h1)
    endtask
    task t_abort;
        panel.press(6'h20);
        wait_mode(2'h3);
        `CHK(step_out, 5'h01)
        panel.press(6'h01);
        `CHK(step_out, 5'h02)
        bus(1'b1, 8'hA8, 32'h01234);
        panel.press(6'h20);
        wait_mode(2'h1);
        bus(1'b0, 8'hA8, 32'h0);
        `CHK(rd, 32'h02710)
    endtask
    task t_skip;
        panel.press(6'h20);
        panel.press(6'h01);
        panel.press(6'h10);
        `CHK(step_out, 5'h05)
        panel.press(6'h01);
        `CHK(step_out, 5'h06)
        panel.press(6'h02);
        panel.press(6'h01);
        `CHK(step_out, 5'h07)
        panel.press(6'h20);
        wait_mode(2'h1);
        bus(1'b0, 8'h98, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    task t_idle;
        int n;
        logic c;
        panel.press(6'h20);
        n = 0;
        c = cursor_on;
        repeat (180) begin
            @(posedge clk);
            if (cursor_on !== c) n++;
            c = cursor_on;
        end
        `CHK(n > 40, 1'b1)
        `CHK(mode_out, 2'h3)
        wait_mode(2'h1);
    endtask
    task t_walk;
        panel.press(6'h20);
        panel.press(6'h01);
        panel.press(6'h01);
        `CHK(step_out, 5'h03)
        panel.press(6'h02);
        repeat (11) panel.press(6'h01);
        `CHK(step_out, 5'h18)
        repeat (6) panel.press(6'h01);
        `CHK(step_out, 5'h10)
        panel.press(6'h18);
        `CHK(step_out, 5'h11)
        repeat (5) panel.press(6'h01);
        `CHK(step_out, 5'h16)
        panel.press(6'h01);
        wait_mode(2'h1);
        `CHK(code_dashes, 1'b1)
        panel.press(6'h20);
        panel.press(6'h01);
        panel.press(6'h01);
        `CHK(step_out, 5'h02)
        panel.press(6'h20);
        wait_mode(2'h1);
    endtask
    initial begin
        panel.hold(6'h01);
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_lamp();
        t_defaults();
        t_relay();
        t_bus();
        t_abort();
        t_skip();
        t_idle();
        t_walk();
        panel.hold(6'h01);
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_lamp();
        `CHK(code_dashes, 1'b0)
        bus(1'b0, 8'h8C, 32'h0);
        `CHK(rd, 32'h0)
        summarize();
    end
endmodule // kmc_mode_ctrl_bench
